/* ambient_defines.svh */
// Purpose: register offsets, field positions, reset values and timing
// Assumes: 125 MHz system clock
// Notes:   times are kept in their own unit; cycle and tick counts derive
`ifndef AMBIENT_DEFINES_SVH
`define AMBIENT_DEFINES_SVH

`define REG_ONOFF        8'h00
`define REG_DIM_MODE     8'h02
`define REG_HOST_CUR     8'h05
`define REG_SLOPE        8'h0a
`define REG_SENSE_CFG    8'h0c
`define REG_RESULT       8'h0d
`define REG_KEY_LEVEL    8'h0f
`define REG_TABLE_PAGE   4'h1

`define ALC_EN_BIT       0
`define KEY_ALC_BIT      1
`define MAIN_ON_BIT      2
`define CAI_EN_BIT       7
`define CAI_COMBINE_BIT  6
`define BIAS_SYNC_BIT    7
`define CURVE_BIT        6
`define PERIOD_MSB       5
`define PERIOD_LSB       4
`define OFFSET_MSB       3

`define ONOFF_RST        8'h00
`define DIM_MODE_RST     8'h00
`define HOST_CUR_RST     8'h00
`define SLOPE_RST        8'h00
`define SENSE_CFG_RST    8'h00
`define KEY_LEVEL_RST    8'ha3

// entry n sits in byte n
`define TABLE_INIT  128'hf9e4d5c6b6a79889796a5b4c3c2d1e0f
`define LOG_BOUNDS  128'hc891694b36271c140e0a070503020100
`define PASS_BOUNDS 128'hb6a99c9084786c6054483c30251b1200

`define CLK_NS           8
`define TICK_NS          25000
`define TICK_CYC         (`TICK_NS / `CLK_NS)
`define PERIOD0_MS       520
`define PERIOD1_MS       1050
`define PERIOD2_MS       1570
`define PERIOD3_MS       2100
`define DISCARD_MS       64
`define SAMPLE_WIN_US    16400
`define SAMPLE_COUNT     16
`define SLOPE_UNIT_US    500
`define MS_TICKS(ms)     ((ms) * 1000000 / `TICK_NS)
`define SAMPLE_TICKS     (`SAMPLE_WIN_US * 1000 / (`SAMPLE_COUNT * `TICK_NS))
`define SLOPE_UNIT_TICKS (`SLOPE_UNIT_US * 1000 / `TICK_NS)

`endif

/* ambient_pkg.sv */
// Purpose: shared types of the ambient light control block
// Assumes: nothing
// Notes:   constants live in ambient_defines.svh
package ambient_pkg;
  typedef logic [7:0] code_t;
  typedef logic [3:0] level_t;
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b000001,
    ST_DISCARD = 6'b000010,
    ST_SAMPLE  = 6'b000100,
    ST_STORE   = 6'b001000,
    ST_LOOKUP  = 6'b010000,
    ST_APPLY   = 6'b100000
  } meas_state_e;
endpackage

/* current_table.sv */
// Purpose: level to current code table, rewritable by software
// Assumes: one write port and one registered read port
// Notes:   entries reload their built-in values on reset
`include "ambient_defines.svh"

module current_table #(
  parameter int           DEPTH = 16,
  parameter int           WIDTH = 8,
  parameter int           AW    = 4,
  parameter [DEPTH*WIDTH-1:0] INIT = `TABLE_INIT
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= INIT[i*WIDTH +: WIDTH];
      end else if (wr_en && wr_addr == AW'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule // current_table

/* ambient_light_ctrl.sv */
// Purpose: periodic ambient measurement and main backlight current control
// Assumes: register port comes from the serial front end on sys_clk;
//          the adc macro and content pwm filter run on sys_clk
// Notes:   table entries are write-only from the register port
`include "ambient_defines.svh"

// Summary of operation
// - latest processed ambient result readable at register 0Dh.
// - levels map to current codes through a table; software may rewrite.
// - ambient path drives brightness when enabled; host control after reset.
// - register 00h holds separate ambient and keypad ambient enables.
// - with bias sync clear, sensor bias turns on as soon as ambient control is enabled.
// - bias sync bit limits bias to measurements; else on while enabled.
// - measurement repeats every 0.52, 1.05, 1.57 or 2.10 s.
// - sixteen levels; curve bit picks log conversion or bypass.
// - log conversion uses bounds 0 to 200 for levels 0 to F.
// - bypass uses bounds 0 to 182 for levels 0 to F.
// - table resets to 0F..F9 and each entry is writable.
// - sensor voltage digitised by an 8-bit adc, bias nominally 3 V.
// - adc and synced bias powered only during measurement.
// - samples during the first 64 ms of a measurement are discarded.
// - sixteen samples in 16.4 ms averaged and stored at 0Dh.
// - current zero when off; pwm when 02h bit 7 set; else ambient when enabled, else host.
// - rise and fall slope times in 0Ah, default zero meaning immediate.
// - ramp moves one 0.1 mA code per programmed slope time.
// - signed offset in 0Ch bits 3..0 corrects the adc average.
// - host, ambient, pwm or pwm combined; slope only without pwm.
// - current code selects sink current in 0.1 mA steps, 256 codes.
// - content pwm dimming disables slope ramping automatically.
module ambient_light_ctrl #(
  parameter int TICK_CYC      = `TICK_CYC,
  parameter int PERIOD0_TICKS = `MS_TICKS(`PERIOD0_MS),
  parameter int PERIOD1_TICKS = `MS_TICKS(`PERIOD1_MS),
  parameter int PERIOD2_TICKS = `MS_TICKS(`PERIOD2_MS),
  parameter int PERIOD3_TICKS = `MS_TICKS(`PERIOD3_MS),
  parameter int DISCARD_TICKS = `MS_TICKS(`DISCARD_MS),
  parameter int SAMPLE_TICKS  = `SAMPLE_TICKS,
  parameter int SLOPE_TICKS   = `SLOPE_UNIT_TICKS
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire ambient_pkg::code_t adc_data,
  input  wire logic          adc_valid,
  input  wire ambient_pkg::code_t content_pwm_level,
  output logic               sensor_bias_enable,
  output logic               adc_power,
  output logic               adc_start,
  output ambient_pkg::code_t main_backlight_sink,
  output ambient_pkg::level_t brightness_level,
  output logic               keypad_light
);
  import ambient_pkg::*;

  // register group
  logic [7:0] onoff_q, onoff_d, dim_q, dim_d, host_q, host_d;
  logic [7:0] slope_q, slope_d, cfg_q, cfg_d, key_q, key_d, rdata_d;
  logic       tbl_we;
  code_t      tbl_rdata;
  // measurement group
  meas_state_e st_q, st_d;
  logic [11:0] div_q, div_d;
  logic [19:0] per_q, per_d, tmr_q, tmr_d, period_ticks;
  logic [4:0]  cnt_q, cnt_d;
  logic [11:0] acc_q, acc_d;
  code_t       result_q, result_d, amb_tgt_q, amb_tgt_d, corrected;
  level_t      level_q, level_d;
  logic        start_q, start_d, keyl_q, keyl_d, tick;
  logic [9:0]  off_sum;
  // ramp group
  code_t       cur_q, cur_d, base, tgt;
  logic [8:0]  rcnt_q, rcnt_d, wait_lim;
  logic [15:0] prod;
  logic [3:0]  scode;
  logic        alc_en, main_on, cai_en, slope_on;

  assign alc_en  = onoff_q[`ALC_EN_BIT];
  assign main_on = onoff_q[`MAIN_ON_BIT];
  assign cai_en  = dim_q[`CAI_EN_BIT];

  function automatic level_t quantise(input code_t c, input logic pass);
    logic [127:0] b;
    level_t       l;
    b = pass ? `PASS_BOUNDS : `LOG_BOUNDS;
    l = 4'h0;
    for (int i = 1; i < 16; i++) begin
      if (c >= b[i*8 +: 8]) begin
        l = 4'(i);
      end
    end
    return l;
  endfunction

  always_comb begin
    onoff_d = onoff_q;
    dim_d   = dim_q;
    host_d  = host_q;
    slope_d = slope_q;
    cfg_d   = cfg_q;
    key_d   = key_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `REG_ONOFF:     onoff_d = reg_wdata;
        `REG_DIM_MODE:  dim_d   = reg_wdata;
        `REG_HOST_CUR:  host_d  = reg_wdata;
        `REG_SLOPE:     slope_d = reg_wdata;
        `REG_SENSE_CFG: cfg_d   = reg_wdata;
        `REG_KEY_LEVEL: key_d   = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_ONOFF:     rdata_d = onoff_q;
        `REG_DIM_MODE:  rdata_d = dim_q;
        `REG_HOST_CUR:  rdata_d = host_q;
        `REG_SLOPE:     rdata_d = slope_q;
        `REG_SENSE_CFG: rdata_d = cfg_q;
        `REG_RESULT:    rdata_d = result_q;
        `REG_KEY_LEVEL: rdata_d = key_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  // writes from software reach the table directly
  assign tbl_we = reg_wr && reg_addr[7:4] == `REG_TABLE_PAGE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      onoff_q   <= `ONOFF_RST;
      dim_q     <= `DIM_MODE_RST;
      host_q    <= `HOST_CUR_RST;
      slope_q   <= `SLOPE_RST;
      cfg_q     <= `SENSE_CFG_RST;
      key_q     <= `KEY_LEVEL_RST;
      reg_rdata <= 8'h00;
    end else begin
      onoff_q   <= onoff_d;
      dim_q     <= dim_d;
      host_q    <= host_d;
      slope_q   <= slope_d;
      cfg_q     <= cfg_d;
      key_q     <= key_d;
      reg_rdata <= rdata_d;
    end
  end

  current_table u_table (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (tbl_we),
    .wr_addr (reg_addr[3:0]),
    .wr_data (reg_wdata),
    .rd_addr (level_q),
    .rd_data (tbl_rdata)
  );

  always_comb begin
    case (cfg_q[`PERIOD_MSB:`PERIOD_LSB])
      2'h0:    period_ticks = 20'(PERIOD0_TICKS);
      2'h1:    period_ticks = 20'(PERIOD1_TICKS);
      2'h2:    period_ticks = 20'(PERIOD2_TICKS);
      default: period_ticks = 20'(PERIOD3_TICKS);
    endcase
    // average plus signed offset, clamped rather than wrapped
    off_sum = {2'b00, acc_q[11:4]} + {{6{cfg_q[`OFFSET_MSB]}}, cfg_q[3:0]};
    if (off_sum[9]) begin
      corrected = 8'h00;
    end else if (off_sum[8]) begin
      corrected = 8'hff;
    end else begin
      corrected = off_sum[7:0];
    end
  end

  always_comb begin
    tick      = div_q == 12'(TICK_CYC - 1);
    div_d     = tick ? 12'h000 : div_q + 12'h001;
    st_d      = st_q;
    per_d     = per_q;
    tmr_d     = tmr_q;
    cnt_d     = cnt_q;
    acc_d     = acc_q;
    result_d  = result_q;
    level_d   = level_q;
    amb_tgt_d = amb_tgt_q;
    keyl_d    = keyl_q;
    start_d   = 1'b0;
    if (tick && per_q != 20'h00000) begin
      per_d = per_q - 20'h00001;
    end
    if (!alc_en) begin
      st_d  = ST_IDLE;
      per_d = 20'h00000;
      tmr_d = 20'h00000;
      keyl_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tick && per_q == 20'h00000) begin
            st_d  = ST_DISCARD;
            per_d = period_ticks - 20'h00001;
            tmr_d = 20'h00000;
          end
        end
        ST_DISCARD: begin
          // the sensor output is still settling; nothing is converted
          if (tick) begin
            tmr_d = tmr_q + 20'h00001;
            if (tmr_q == 20'(DISCARD_TICKS - 1)) begin
              st_d  = ST_SAMPLE;
              tmr_d = 20'h00000;
              cnt_d = 5'h00;
              acc_d = 12'h000;
            end
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            tmr_d = tmr_q + 20'h00001;
            if (tmr_q == 20'(SAMPLE_TICKS - 1)) begin
              tmr_d   = 20'h00000;
              start_d = 1'b1;
            end
          end
          if (adc_valid) begin
            acc_d = acc_q + {4'h0, adc_data};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(`SAMPLE_COUNT - 1)) begin
              st_d = ST_STORE;
            end
          end
        end
        ST_STORE: begin
          result_d = corrected;
          level_d  = quantise(corrected, cfg_q[`CURVE_BIT]);
          st_d     = ST_LOOKUP;
        end
        ST_LOOKUP: st_d = ST_APPLY;
        ST_APPLY: begin
          amb_tgt_d = tbl_rdata;
          if ({1'b0, level_q} >= {1'b0, key_q[7:4]}) begin
            keyl_d = 1'b0;
          end else if ({1'b0, level_q} + {1'b0, key_q[3:0]} + 5'h01
                       <= {1'b0, key_q[7:4]}) begin
            keyl_d = 1'b1;
          end
          st_d = ST_IDLE;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q      <= ST_IDLE;
      div_q     <= 12'h000;
      per_q     <= 20'h00000;
      tmr_q     <= 20'h00000;
      cnt_q     <= 5'h00;
      acc_q     <= 12'h000;
      result_q  <= 8'h00;
      level_q   <= 4'h0;
      amb_tgt_q <= 8'h00;
      keyl_q    <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      div_q     <= div_d;
      per_q     <= per_d;
      tmr_q     <= tmr_d;
      cnt_q     <= cnt_d;
      acc_q     <= acc_d;
      result_q  <= result_d;
      level_q   <= level_d;
      amb_tgt_q <= amb_tgt_d;
      keyl_q    <= keyl_d;
      start_q   <= start_d;
    end
  end

  assign adc_power = st_q == ST_DISCARD || st_q == ST_SAMPLE;
  assign sensor_bias_enable = alc_en &&
      (!cfg_q[`BIAS_SYNC_BIT] || adc_power);
  assign adc_start = start_q;
  assign brightness_level = level_q;
  assign keypad_light = keyl_q && onoff_q[`KEY_ALC_BIT];

  always_comb begin
    base     = alc_en ? amb_tgt_q : host_q;
    prod     = base * content_pwm_level;
    slope_on = main_on && !cai_en;
    if (!main_on) begin
      tgt = 8'h00;
    end else if (cai_en) begin
      tgt = dim_q[`CAI_COMBINE_BIT] ? prod[15:8] : content_pwm_level;
    end else begin
      tgt = base;
    end
    scode    = (tgt > cur_q) ? slope_q[7:4] : slope_q[3:0];
    wait_lim = 9'(scode * SLOPE_TICKS);
    cur_d    = cur_q;
    rcnt_d   = rcnt_q;
    if (!slope_on || cur_q == tgt || scode == 4'h0) begin
      cur_d  = tgt;
      rcnt_d = 9'h000;
    end else if (tick) begin
      // wait first, then move one code of 0.1 mA
      if (rcnt_q >= wait_lim - 9'h001) begin
        cur_d  = (tgt > cur_q) ? cur_q + 8'h01 : cur_q - 8'h01;
        rcnt_d = 9'h000;
      end else begin
        rcnt_d = rcnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_q  <= 8'h00;
      rcnt_q <= 9'h000;
    end else begin
      cur_q  <= cur_d;
      rcnt_q <= rcnt_d;
    end
  end

  assign main_backlight_sink = cur_q;

  sequence s_meas_start;
    st_q == ST_IDLE ##1 st_q == ST_DISCARD;
  endsequence
  sequence s_store_done;
    st_q == ST_STORE ##1 st_q == ST_LOOKUP ##1 st_q == ST_APPLY;
  endsequence

  a_bias_disabled: assert property (@(posedge sys_clk) disable iff (rst)
    !alc_en |-> !sensor_bias_enable) else $error("bias on while disabled");
  a_bias_sync_on: assert property (@(posedge sys_clk) disable iff (rst)
    (alc_en && cfg_q[`BIAS_SYNC_BIT]) |-> sensor_bias_enable == adc_power)
    else $error("synced bias not following measurement");
  a_adc_power_on: assert property (@(posedge sys_clk) disable iff (rst)
    s_meas_start |-> adc_power) else $error("adc unpowered at start");
  a_no_discard_cv: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == ST_DISCARD |=> !adc_start) else $error("conversion in discard");
  a_result_stored: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == ST_STORE |=> result_q == $past(corrected))
    else $error("average not stored");
  a_log_top: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_STORE && !cfg_q[`CURVE_BIT] && corrected >= 8'hc8)
    |=> level_q == 4'hf) else $error("log top level wrong");
  a_pass_level: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == ST_STORE && cfg_q[`CURVE_BIT] && corrected >= 8'h12
     && corrected < 8'h1b) |=> level_q == 4'h1)
    else $error("bypass level wrong");
  a_target_update: assert property (@(posedge sys_clk) disable iff (rst)
    s_store_done |=> amb_tgt_q == $past(tbl_rdata))
    else $error("target not taken from table");
  a_off_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !main_on |=> main_backlight_sink == 8'h00) else $error("off not zero");
  a_ramp_unit: assert property (@(posedge sys_clk) disable iff (rst)
    ($past(slope_on) && $past(scode) != 4'h0 && $past(cur_q) != $past(tgt)
     && $stable(tgt)) |-> (cur_q == $past(cur_q) + 8'h01
     || cur_q == $past(cur_q) - 8'h01 || $stable(cur_q)))
    else $error("ramp step larger than one code");
  a_cai_direct: assert property (@(posedge sys_clk) disable iff (rst)
    (main_on && cai_en && !dim_q[`CAI_COMBINE_BIT]) |=>
    cur_q == $past(content_pwm_level)) else $error("pwm path ramped");
endmodule // ambient_light_ctrl

/* adc_sensor_model.sv */
// Purpose: behavioural light sensor with its 8-bit converter
// Assumes: one conversion per start pulse, answered on sys_clk
// Notes:   data toggles outside valid so a stale code never looks good
module adc_sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       adc_power,
  input  wire logic       adc_start,
  input  wire logic       sensor_bias_enable,
  input  wire logic [7:0] sense,
  input  wire logic       slow,
  output logic      [7:0] adc_data,
  output logic            adc_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  logic       busy_q;

  // an unpowered converter keeps nothing, so losing power is its reset
  always @(posedge sys_clk or negedge adc_power) begin
    if (!adc_power) begin
      busy_q    <= 1'b0;
      wait_q    <= 2'h0;
      adc_valid <= 1'b0;
      adc_data  <= 8'h5a;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_start) begin
        busy_q <= 1'b1;
        wait_q <= slow ? 2'h2 : 2'h0;
      end else if (busy_q && wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end else if (busy_q) begin
        busy_q    <= 1'b0;
        adc_valid <= 1'b1;
        // an unbiased sensor reads dark
        adc_data  <= sensor_bias_enable ? sense : 8'h00;
      end
    end
  end
endmodule // adc_sensor_model

/* tb_top.sv */
// Purpose: self-checking bench for the ambient light control block
// Assumes: shortened tick, period, discard, sample and slope counts
// Notes:   expected codes are built here from level bounds and table
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  localparam logic [127:0] LOGB = 128'hc891694b36271c140e0a070503020100;
  localparam logic [127:0] BYPB = 128'hb6a99c9084786c6054483c30251b1200;
  localparam logic [127:0] TBL  = 128'hf9e4d5c6b6a79889796a5b4c3c2d1e0f;
  // sense, offset, expected result
  localparam logic [23:0] OFS [4] = '{24'h000f00, 24'hff07ff,
                                      24'h640367, 24'h640c60};
  logic       sys_clk;
  logic       rst;
  logic       reg_wr;
  logic       reg_rd;
  logic       adc_valid;
  logic       slow;
  logic       bias;
  logic       adc_power;
  logic       adc_start;
  logic       keypad;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] adc_data;
  logic [7:0] pwm;
  logic [7:0] sense;
  logic [7:0] sink;
  logic [3:0] level;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         rise_cyc;

  ambient_light_ctrl #(.TICK_CYC(TC), .PERIOD0_TICKS(40),
    .PERIOD1_TICKS(50), .PERIOD2_TICKS(60), .PERIOD3_TICKS(70),
    .DISCARD_TICKS(5), .SAMPLE_TICKS(2), .SLOPE_TICKS(2)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_data(adc_data), .adc_valid(adc_valid),
    .content_pwm_level(pwm), .sensor_bias_enable(bias),
    .adc_power(adc_power), .adc_start(adc_start),
    .main_backlight_sink(sink), .brightness_level(level),
    .keypad_light(keypad));

  adc_sensor_model u_sensor (
    .sys_clk(sys_clk), .adc_power(adc_power),
    .adc_start(adc_start), .sensor_bias_enable(bias), .sense(sense),
    .slow(slow), .adc_data(adc_data), .adc_valid(adc_valid));

  task automatic test_done();
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr    = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd   = 1'b0;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic wpw(input logic v);
    int k;
    for (k = 0; k < 2000 && adc_power !== v; k++)
      @(negedge sys_clk);
    chk("adc_power", adc_power, v);
  endtask

  // one full fresh measurement, then time for store, lookup and apply;
  // the tail must end before the next period starts, slow adc included
  task automatic meas();
    int k;
    int starts;
    starts = 0;
    wpw(1'b0);
    wpw(1'b1);
    rise_cyc = cyc;
    for (k = 0; k < 300 && adc_power === 1'b1; k++) begin
      @(negedge sys_clk);
      if (adc_start === 1'b1 && starts == 0)
        chk("discard", k >= 5 * TC - 1, 1'b1);
      if (adc_start === 1'b1)
        starts++;
    end
    chk("starts", 16'(starts), 16'd16);
    repeat (5) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // the planned run needs about 21000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    int k;
    int t;
    logic [7:0] d;
    logic [7:0] bnd;
    logic [3:0] e;
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    pwm       = 8'h00;
    sense     = 8'h00;
    slow      = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h0a, 8'h00);
    rdc(8'h0c, 8'h00);
    rdc(8'h0d, 8'h00);
    rdc(8'h0f, 8'ha3);
    chk("sink", sink, 8'h00);
    wr(8'h05, 8'h40);
    rdc(8'h05, 8'h40);
    wr(8'h00, 8'h04);
    @(negedge sys_clk);
    chk("sink", sink, 8'h40);
    wr(8'h00, 8'h05);
    @(negedge sys_clk);
    chk("bias", bias, 1'b1);
    for (k = 0; k < 64; k++) begin
      if (k[4:0] == 5'h0)
        wr(8'h0c, {1'b0, k[5], 6'h00});
      if (k[4:1] == 4'h0 && k[0])
        continue;
      bnd   = k[5] ? BYPB[k[4:1] * 8 +: 8] : LOGB[k[4:1] * 8 +: 8];
      slow  = k[1];
      sense = bnd - 8'(k[0]);
      e     = k[4:1] - 4'(k[0]);
      meas();
      chk("level", level, e);
      chk("sink", sink, TBL[e * 8 +: 8]);
      rdc(8'h0d, sense);
    end
    for (k = 0; k < 4; k++) begin
      wr(8'h0c, OFS[k][15:8]);
      sense = OFS[k][23:16];
      meas();
      rdc(8'h0d, OFS[k][7:0]);
    end
    wr(8'h0c, 8'h00);
    wr(8'h1c, 8'h55);
    sense = 8'd100;
    meas();
    chk("sink", sink, 8'h55);
    rdc(8'h1c, 8'h00);
    wr(8'h1c, 8'hc6);
    wr(8'h0c, 8'h80);
    meas();
    chk("bias", bias, 1'b0);
    wpw(1'b1);
    chk("bias", bias, 1'b1);
    for (k = 0; k < 4; k++) begin
      wr(8'h0c, 8'(k << 4));
      meas();
      meas();
      t = rise_cyc;
      meas();
      chk("period", 16'(rise_cyc - t), 16'((40 + 10 * k) * TC));
    end
    chk("sink", sink, 8'hc6);
    wr(8'h0a, 8'h11);
    sense = 8'd105;
    meas();
    d = sink;
    chk("early", d < 8'hc8, 1'b1);
    for (k = 0; k < 300 && sink !== 8'hd5; k++) begin
      @(negedge sys_clk);
      if (sink !== d)
        chk("step", 16'(sink - d), 16'd1);
      d = sink;
    end
    chk("ramp", sink, 8'hd5);
    chk("slope", k >= 13 * 2 * TC, 1'b1);
    wr(8'h0a, 8'h10);
    sense = 8'd100;
    meas();
    chk("sink", sink, 8'hc6);
    // pwm alone, then pwm scaling the ambient code c6 of level C
    for (k = 0; k < 2; k++) begin
      pwm = 8'h33 + 8'(k * 8'h4d);
      wr(8'h02, {1'b1, k[0], 6'h00});
      repeat (2) @(negedge sys_clk);
      chk("sink", sink, k[0] ? 8'h63 : 8'h33);
    end
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h07);
    sense = 8'd5;
    meas();
    chk("key", keypad, 1'b1);
    sense = 8'd100;
    meas();
    chk("key", keypad, 1'b0);
    wr(8'h00, 8'h01);
    @(negedge sys_clk);
    chk("sink", sink, 8'h00);
    wr(8'h0d, 8'hff);
    rdc(8'h0d, 8'h64);
    rdc(8'h30, 8'h00);
    wr(8'h00, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("power", adc_power, 1'b0);
    chk("bias", bias, 1'b0);
    test_done();
  end
endmodule // tb_top
